// File: logic/pph_pkg.sv
// Purpose: Shared constants of the four-port parallel handshake block
// Assumes: APB word access, one clock, printed offsets are register indices
// Notes:   Byte address of a register is four times its index
package pph_pkg;

  // Geometry
  localparam int NUM_PORTS = 4;
  localparam int NUM_SEC   = 8;
  localparam int SEC_W     = 8;
  localparam int PIN_W     = 64;

  // Register indices within a port
  localparam logic [4:0] IDX_CTL_A  = 5'h00;
  localparam logic [4:0] IDX_DAT_A  = 5'h01;
  localparam logic [4:0] IDX_CTL_B  = 5'h02;
  localparam logic [4:0] IDX_DAT_B  = 5'h03;
  localparam logic [4:0] PORT_SPAN  = 5'h04;
  // Block-wide event status and mask
  localparam logic [4:0] IDX_STS    = 5'h10;
  localparam logic [4:0] IDX_MSK    = 5'h11;
  localparam logic [4:0] IDX_LAST   = 5'h11;

  // Section control/status field positions
  localparam int CTL_C1_IE   = 0;  // Line 1 edge raises section request
  localparam int CTL_C1_RISE = 1;  // Line 1 active edge: 1 rising, 0 falling
  localparam int CTL_DSEL    = 2;  // Data offset: 1 data, 0 direction
  localparam int CTL_C2_IE   = 3;  // Line 2 edge raises request (input mode)
  localparam int CTL_C2_RISE = 4;  // Line 2 active edge (input mode)
  localparam int CTL_C2_OUT  = 5;  // Line 2 drives busy; bit 3 is then its level
  localparam int CTL_FLAG1   = 6;  // Read-only flag of line 1
  localparam int CTL_FLAG2   = 7;  // Read-only flag of line 2
  localparam int CTL_WR_W    = 6;

  // Reset values
  localparam logic [5:0]  CTL_RST  = 6'h00;
  localparam logic [7:0]  DDR_RST  = 8'h00;
  localparam logic [7:0]  DOUT_RST = 8'h00;
  localparam logic [7:0]  STS_RST  = 8'h00;
  localparam logic [7:0]  MSK_RST  = 8'h00;
  localparam logic [31:0] RD_RST   = 32'h0000_0000;

endpackage

// File: logic/pph_sec_if.sv
// Purpose: Carries one section's register traffic and pin levels
// Assumes: All signals on pclk
// Notes:   top drives requests, sec answers with state
`timescale 1ns/1ps
interface pph_sec_if;
  logic       wr_ctl;   // Write control register
  logic       wr_dat;   // Write data or direction
  logic       rd_dat;   // Data read completes
  logic [7:0] wdata;
  logic       c1_in;    // Synchronised line 1
  logic       c2_in;    // Synchronised line 2
  logic [7:0] ctl_rd;   // Control with flags
  logic [7:0] ddr;
  logic [7:0] dout;
  logic       c2_val;
  logic       c2_oe;
  logic       irq;
  logic       evt;      // Flag event this cycle

  modport top (output wr_ctl, wr_dat, rd_dat, wdata, c1_in, c2_in,
               input  ctl_rd, ddr, dout, c2_val, c2_oe, irq, evt);
  modport sec (input  wr_ctl, wr_dat, rd_dat, wdata, c1_in, c2_in,
               output ctl_rd, ddr, dout, c2_val, c2_oe, irq, evt);
endinterface // pph_sec_if

// File: logic/pph_section.sv
// Purpose: One 8-bit section: direction, output data, two handshake lines
// Assumes: Pin levels arrive synchronised
// Notes:   Flags clear on a data read; an edge in that cycle wins
`timescale 1ns/1ps
module pph_section (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link to the port logic
  pph_sec_if.sec   sec
);

  ////////////////////////////////////////////////////////////////////////
  // Edge test on a handshake line
  function automatic logic edge_hit(input logic cur, input logic prev, input logic rise);
    edge_hit = rise ? (cur & ~prev) : (~cur & prev);
  endfunction

  logic [5:0] ctl,     next_ctl;
  logic [7:0] ddr,     next_ddr;
  logic [7:0] dout,    next_dout;
  logic       flag1,   next_flag1;
  logic       flag2,   next_flag2;
  logic       c1_prev, c2_prev;
  logic       c2_val,  next_c2_val;
  logic       c2_oe,   next_c2_oe;
  logic       irq,     next_irq;
  logic       ev1,     ev2;

  ////////////////////////////////////////////////////////////////////////
  // Next state of the section
  always_comb begin
    next_ctl  = ctl;
    next_ddr  = ddr;
    next_dout = dout;
    if (sec.wr_ctl) begin
      next_ctl = sec.wdata[pph_pkg::CTL_WR_W-1:0];
    end
    if (sec.wr_dat) begin
      if (ctl[pph_pkg::CTL_DSEL]) begin
        next_dout = sec.wdata;
      end else begin
        next_ddr = sec.wdata;
      end
    end
    ev1 = edge_hit(sec.c1_in, c1_prev, ctl[pph_pkg::CTL_C1_RISE]);
    // line 2 as input or busy
    ev2 = ~ctl[pph_pkg::CTL_C2_OUT] & edge_hit(sec.c2_in, c2_prev, ctl[pph_pkg::CTL_C2_RISE]);
    next_flag1 = ev1 | (flag1 & ~sec.rd_dat);
    next_flag2 = ev2 | (flag2 & ~sec.rd_dat);
    next_c2_oe  = next_ctl[pph_pkg::CTL_C2_OUT];
    next_c2_val = next_ctl[pph_pkg::CTL_C2_OUT] & next_ctl[pph_pkg::CTL_C2_IE];
    next_irq = (next_flag1 & next_ctl[pph_pkg::CTL_C1_IE])
             | (next_flag2 & next_ctl[pph_pkg::CTL_C2_IE] & ~next_ctl[pph_pkg::CTL_C2_OUT]);
  end

  ////////////////////////////////////////////////////////////////////////
  // reset to inputs, all off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl     <= pph_pkg::CTL_RST;
      ddr     <= pph_pkg::DDR_RST;
      dout    <= pph_pkg::DOUT_RST;
      flag1   <= 1'b0;
      flag2   <= 1'b0;
      c1_prev <= 1'b0;
      c2_prev <= 1'b0;
      c2_val  <= 1'b0;
      c2_oe   <= 1'b0;
      irq     <= 1'b0;
    end else begin
      ctl     <= next_ctl;
      ddr     <= next_ddr;
      dout    <= next_dout;
      flag1   <= next_flag1;
      flag2   <= next_flag2;
      c1_prev <= sec.c1_in;
      c2_prev <= sec.c2_in;
      c2_val  <= next_c2_val;
      c2_oe   <= next_c2_oe;
      irq     <= next_irq;
    end
  end

  // State back to the port logic
  assign sec.ctl_rd = {flag2, flag1, ctl};
  assign sec.ddr    = ddr;
  assign sec.dout   = dout;
  assign sec.c2_val = c2_val;
  assign sec.c2_oe  = c2_oe;
  assign sec.irq    = irq;
  assign sec.evt    = ev1 | ev2;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_FLAG1_SET: assert property (@(posedge pclk) disable iff (!presetn)
    ev1 |=> flag1 && sec.ctl_rd[pph_pkg::CTL_FLAG1])
    else $error("line 1 edge did not set flag");
  AST_FLAG_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (sec.rd_dat && !ev1 && !ev2) |=> !flag1 && !flag2)
    else $error("data read did not clear flags");
  AST_BUSY_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    (ctl[pph_pkg::CTL_C2_OUT] && !sec.wr_ctl) |=> c2_oe && (c2_val == $past(ctl[pph_pkg::CTL_C2_IE])) && !ev2)
    else $error("line 2 busy output wrong");
  AST_SEC_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    irq == ((flag1 && ctl[pph_pkg::CTL_C1_IE])
         || (flag2 && ctl[pph_pkg::CTL_C2_IE] && !ctl[pph_pkg::CTL_C2_OUT])))
    else $error("section request does not match flags");

endmodule // pph_section

// File: logic/pph_top.sv
// Purpose: Four parallel ports, two handshaking sections each, on APB
// Assumes: Pins are asynchronous and pass two flops; APB on pclk
// Notes:   Index i sits at byte address 4*i; unmapped access gets pslverr
//          Map per port n (index 4n+k): k=0 control A, 1 data A, 2 control B, 3 data B
//          Index 16 event status (write one to clear), index 17 event mask
//          Control bits: 0 line 1 request enable, 1 line 1 rising edge
//            2 data offset selects data (1) or direction (0)
//            3 line 2 request enable, or busy level in output mode
//            4 line 2 rising edge, 5 line 2 output mode
//            6 line 1 flag, 7 line 2 flag (read only)
//          Flags set whatever the enables; enables gate only the requests
//          A data read with bit 2 set clears both flags of that section
//          Pins pass two flops, so a pin edge shows as a flag three cycles on
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module pph_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Data lines, eight per section
  input  wire logic [63:0] pd_in,
  output logic      [63:0] pd_out,
  output logic      [63:0] pd_oe,
  // Handshake lines, one of each per section
  input  wire logic [7:0]  hs1_in,
  input  wire logic [7:0]  hs2_in,
  output logic      [7:0]  hs2_out,
  output logic      [7:0]  hs2_oe,
  // Interrupt requests
  output logic      [7:0]  sec_irq,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode: index from byte address, and its validity
  function automatic logic [4:0] idx_of(input logic [7:0] a);
    idx_of = a[6:2];
  endfunction

  function automatic logic idx_ok(input logic [7:0] a);
    idx_ok = (a[1:0] == 2'h0) && !a[7] && (idx_of(a) <= pph_pkg::IDX_LAST);
  endfunction

  function automatic logic [2:0] sec_of(input logic [4:0] i);
    sec_of = {i[3:2], i[1]};
  endfunction

  localparam int SYN_W = pph_pkg::PIN_W + 2 * pph_pkg::NUM_SEC;

  logic [SYN_W-1:0] sync1;
  logic [SYN_W-1:0] sync2;
  logic [63:0]      pins;
  logic [7:0]       c1s;
  logic [7:0]       c2s;

  ////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for every pin input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {hs2_in, hs1_in, pd_in};
      sync2 <= sync1;
    end
  end

  assign pins = sync2[63:0];
  assign c1s  = sync2[71:64];
  assign c2s  = sync2[79:72];

  ////////////////////////////////////////////////////////////////////////
  // Sections
  logic [4:0] idx;
  logic       setup;
  logic       done;
  logic       hit_sec;
  logic [7:0] sec_ctl  [pph_pkg::NUM_SEC];
  logic [7:0] sec_ddr  [pph_pkg::NUM_SEC];
  logic [7:0] sec_dout [pph_pkg::NUM_SEC];
  logic [7:0] evt_vec;

  assign idx     = idx_of(paddr);
  assign setup   = psel & ~penable;
  assign done    = psel & penable & pready;
  assign hit_sec = idx_ok(paddr) & (idx < pph_pkg::IDX_STS);

  pph_sec_if sif [pph_pkg::NUM_SEC] ();

  for (genvar s = 0; s < pph_pkg::NUM_SEC; s++) begin : g_sec
    logic sel;
    // low bit picks control or data
    assign sel             = done & hit_sec & (sec_of(idx) == 3'(s));
    assign sif[s].wr_ctl   = sel & pwrite & ~idx[0];
    assign sif[s].wr_dat   = sel & pwrite & idx[0];
    assign sif[s].rd_dat   = sel & ~pwrite & idx[0] & sif[s].ctl_rd[pph_pkg::CTL_DSEL];
    assign sif[s].wdata    = pwdata[7:0];
    assign sif[s].c1_in    = c1s[s];
    assign sif[s].c2_in    = c2s[s];
    assign sec_ctl[s]      = sif[s].ctl_rd;
    assign sec_ddr[s]      = sif[s].ddr;
    assign sec_dout[s]     = sif[s].dout;
    assign evt_vec[s]      = sif[s].evt;
    assign pd_out[8*s +: 8] = sif[s].dout;
    assign pd_oe[8*s +: 8]  = sif[s].ddr;
    assign hs2_out[s]       = sif[s].c2_val;
    assign hs2_oe[s]        = sif[s].c2_oe;
    assign sec_irq[s]       = sif[s].irq;

    pph_section u_sec (
      .pclk    (pclk),
      .presetn (presetn),
      .sec     (sif[s])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Block-wide event status (write one to clear) and mask
  logic [7:0] sts, next_sts;
  logic [7:0] msk, next_msk;
  logic       next_irq;
  logic       wr_sts;
  logic       wr_msk;

  assign wr_sts = done & pwrite & idx_ok(paddr) & (idx == pph_pkg::IDX_STS);
  assign wr_msk = done & pwrite & idx_ok(paddr) & (idx == pph_pkg::IDX_MSK);

  // Events win over a clear in the same cycle
  always_comb begin
    next_sts = (sts & ~(wr_sts ? pwdata[7:0] : 8'h00)) | evt_vec;
    next_msk = wr_msk ? pwdata[7:0] : msk;
    next_irq = |(next_sts & next_msk);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts <= pph_pkg::STS_RST;
      msk <= pph_pkg::MSK_RST;
      irq <= 1'b0;
    end else begin
      sts <= next_sts;
      msk <= next_msk;
      irq <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB answer: pready in the first cycle of the access phase, the cycle after setup
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [2:0]  rs;
  logic [7:0]  rval;

  always_comb begin
    rs   = sec_of(idx);
    rval = 8'h00;
    if (hit_sec) begin
      if (!idx[0]) begin
        rval = sec_ctl[rs];
      end else if (sec_ctl[rs][pph_pkg::CTL_DSEL]) begin
        rval = (sec_dout[rs] & sec_ddr[rs]) | (pins[8*rs +: 8] & ~sec_ddr[rs]);
      end else begin
        rval = sec_ddr[rs];
      end
    end else if (idx == pph_pkg::IDX_STS) begin
      rval = sts;
    end else if (idx == pph_pkg::IDX_MSK) begin
      rval = msk;
    end
    next_pready  = setup;
    next_pslverr = setup & ~idx_ok(paddr);
    next_prdata  = prdata;
    if (setup) begin
      next_prdata = idx_ok(paddr) ? {24'h000000, rval} : pph_pkg::RD_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= pph_pkg::RD_RST;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_PREADY_NEXT: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !idx_ok(paddr)) |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");
  AST_DIR_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (done && pwrite && idx_ok(paddr) && idx == pph_pkg::IDX_DAT_A && !sec_ctl[0][pph_pkg::CTL_DSEL])
    |=> pd_oe[7:0] == $past(pwdata[7:0]))
    else $error("direction write of port 0 section A lost");
  AST_PORT3_CTL: assert property (@(posedge pclk) disable iff (!presetn)
    (done && pwrite && paddr == 8'h38) |=> sec_ctl[7][5:0] == $past(pwdata[5:0]))
    else $error("index 14 did not reach port 3 section B control");
  AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(sts & msk))
    else $error("interrupt level does not follow status and mask");
  AST_EVT_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    evt_vec[0] |=> sts[0] ##1 (sts[0] || $past(wr_sts && pwdata[0])))
    else $error("event status bit not sticky");
  AST_RESET_CLEAN: assert property (@(posedge pclk)
    !presetn |=> (pd_oe == 64'h0 && hs2_oe == 8'h00 && sec_irq == 8'h00 && !irq) || !presetn)
    else $error("outputs not quiet after reset");
  AST_BUSY_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    hs2_oe[1] |-> sec_ctl[1][pph_pkg::CTL_C2_OUT])
    else $error("busy line driven while not in output mode");

  // Bus answer, status, mapping and section flag checks
  // error only with ready
  AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RDATA_BYTE: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  AST_STS_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_sts && pwdata[1] && !evt_vec[1]) |=> !sts[1])
    else $error("status bit 1 not cleared by write one");
  AST_STS_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (evt_vec != 8'h00) |=> ((sts & $past(evt_vec)) == $past(evt_vec)))
    else $error("event did not set its status bit");
  AST_STS_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (sts[1] && !wr_sts) |=> sts[1])
    else $error("status bit 1 dropped without a clear");
  AST_MSK_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_msk |=> msk == $past(pwdata[7:0]))
    else $error("mask write lost");
  AST_BAD_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (done && pwrite && !idx_ok(paddr)) |=> msk == $past(msk) && sec_ddr[0] == $past(sec_ddr[0]))
    else $error("refused write changed a register");
  AST_DOUT_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (done && pwrite && idx_ok(paddr) && idx == pph_pkg::IDX_DAT_A && sec_ctl[0][pph_pkg::CTL_DSEL])
    |=> pd_out[7:0] == $past(pwdata[7:0]))
    else $error("data write of port 0 section A lost");
  AST_DIR_WRITE_B: assert property (@(posedge pclk) disable iff (!presetn)
    (done && pwrite && idx_ok(paddr) && idx == pph_pkg::IDX_DAT_B && !sec_ctl[1][pph_pkg::CTL_DSEL])
    |=> pd_oe[15:8] == $past(pwdata[7:0]))
    else $error("direction write of port 0 section B lost");
  AST_CTL_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && idx_ok(paddr) && idx == pph_pkg::IDX_CTL_A) |=> prdata[7:0] == $past(sec_ctl[0]))
    else $error("control read of section A wrong");
  AST_PORT1_CTL: assert property (@(posedge pclk) disable iff (!presetn)
    (done && pwrite && idx_ok(paddr) && idx == pph_pkg::PORT_SPAN) |=> sec_ctl[2][5:0] == $past(pwdata[5:0]))
    else $error("index 4 did not reach port 1 section A control");
  AST_REQ_NEEDS_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    sec_irq[0] |-> sec_ctl[0][pph_pkg::CTL_FLAG2:pph_pkg::CTL_FLAG1] != 2'b00)
    else $error("section request without a flag");
  // no line 2 flag when busy
  AST_BUSY_NO_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (hs2_oe[0] && !sec_ctl[0][pph_pkg::CTL_FLAG2]) |=> !sec_ctl[0][pph_pkg::CTL_FLAG2])
    else $error("line 2 flag set in output mode");
  AST_READY_AFTER_SETUP: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> $past(setup))
    else $error("pready without a setup cycle");

endmodule // pph_top

// File: bench/pph_periph.sv
// Purpose: Peripheral on the line side of the parallel ports
// Assumes: Bench sets the levels that the peripheral drives
// Notes:   A line the block drives reads back the block's own level
`timescale 1ns/1ps
module pph_periph (
  // Block outputs
  input  wire logic [63:0] pd_out,
  input  wire logic [63:0] pd_oe,
  input  wire logic [7:0]  hs2_out,
  input  wire logic [7:0]  hs2_oe,
  // Peripheral levels
  input  wire logic [63:0] drv_data,
  input  wire logic [7:0]  drv_hs1,
  input  wire logic [7:0]  drv_hs2,
  // Wire levels back to the block
  output logic      [63:0] pd_in,
  output logic      [7:0]  hs1_in,
  output logic      [7:0]  hs2_in
);
  // Each wire carries whoever drives it, never both
  assign pd_in  = (pd_oe & pd_out) | (~pd_oe & drv_data);
  assign hs1_in = drv_hs1;
  assign hs2_in = (hs2_oe & hs2_out) | (~hs2_oe & drv_hs2);
endmodule // pph_periph

// File: bench/pph_top_tb.sv
// Purpose: Self-checking bench of the four-port handshake block
// Assumes: APB master on pclk, peripheral model on the lines
// Notes:   Pin changes need a few cycles to pass the synchronisers
`timescale 1ns/1ps
module pph_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [7:0]  paddr, hs1_in, hs2_in, hs2_out, hs2_oe, sec_irq, drv_hs1, drv_hs2;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] pd_in, pd_out, pd_oe, drv_data;
  int          err_total, checks, cyc;

  ////////////////////////////////////////////////////////////////
  // Design and peripheral
  pph_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe), .hs1_in(hs1_in), .hs2_in(hs2_in),
    .hs2_out(hs2_out), .hs2_oe(hs2_oe), .sec_irq(sec_irq), .irq(irq));
  pph_periph per (.pd_out(pd_out), .pd_oe(pd_oe), .hs2_out(hs2_out), .hs2_oe(hs2_oe),
    .drv_data(drv_data), .drv_hs1(drv_hs1), .drv_hs2(drv_hs2), .pd_in(pd_in),
    .hs1_in(hs1_in), .hs2_in(hs2_in));

  ////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One comparison
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) chk(32'h0, 32'h1, "no answer");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Byte address of register r of port p
  function automatic logic [7:0] ad(input int p, input int r);
    return 8'((4 * p + r) * 4);
  endfunction

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 16; i++) rchk(ad(i / 4, i % 4), 32'h0, "reset reg");
    rchk(8'h40, 32'h0, "reset status");
    chk(pd_oe[31:0] | pd_oe[63:32], 32'h0, "reset dir");
    chk({hs2_oe, sec_irq, 7'h0, irq}, 32'h0, "reset lines");
  endtask

  task automatic t_dir();
    logic [7:0] dr, c, d;
    for (int s = 0; s < 8; s++) begin
      dr = 8'h5A ^ 8'(s);
      c = ad(s / 2, 2 * (s % 2));
      d = c + 8'h04;
      apb(1'b1, c, 32'h0);
      apb(1'b1, d, {24'h0, dr});
      apb(1'b1, c, 32'h04);
      apb(1'b1, d, 32'hC3);
      wt(4);
      chk(pd_oe[8*s+:8], dr, "direction");
      chk(pd_out[8*s+:8], 8'hC3, "out data");
      rchk(d, (8'hC3 & dr) | (drv_data[8*s+:8] & ~dr), "data read");
      rchk(c, 32'h04, "ctl read");
    end
    chk(pd_oe[7:0], 8'h5A, "section 0 kept");
  endtask

  task automatic t_hs1();
    apb(1'b1, 8'h08, 32'h07);
    apb(1'b1, 8'h44, 32'h02);
    drv_hs1[1] <= 1'b1;
    wt(6);
    chk(sec_irq[1], 1'b1, "sec req");
    chk(irq, 1'b1, "irq");
    rchk(8'h08, 32'h47, "flag1");
    rchk(8'h40, 32'h02, "status");
    apb(1'b0, 8'h0C, 32'h0);
    wt(2);
    chk(sec_irq[1], 1'b0, "req drop");
    rchk(8'h08, 32'h07, "flag clr");
    apb(1'b1, 8'h40, 32'h02);
    wt(2);
    chk(irq, 1'b0, "irq clr");
    rchk(8'h40, 32'h0, "status clr");
    drv_hs1[1] <= 1'b0;
    wt(6);
    rchk(8'h08, 32'h07, "wrong edge");
    apb(1'b1, 8'h08, 32'h06);
    apb(1'b1, 8'h44, 32'h0);
    drv_hs1[1] <= 1'b1;
    wt(6);
    rchk(8'h08, 32'h46, "flag no ie");
    chk({sec_irq[1], irq}, 2'b00, "disabled");
    rchk(8'h40, 32'h02, "masked status");
  endtask

  task automatic t_hs2();
    apb(1'b1, 8'h00, 32'h28);
    wt(2);
    chk({hs2_oe[0], hs2_out[0]}, 2'b11, "busy high");
    chk(hs2_oe[7:1], 7'h00, "other lines idle");
    apb(1'b1, 8'h00, 32'h20);
    wt(4);
    chk(hs2_out[0], 1'b0, "busy low");
    rchk(8'h00, 32'h20, "out no flag");
    apb(1'b1, 8'h00, 32'h0C);
    wt(2);
    chk(hs2_oe[0], 1'b0, "line2 input");
    drv_hs2[0] <= 1'b0;
    wt(6);
    rchk(8'h00, 32'h8C, "flag2");
    chk(sec_irq[0], 1'b1, "sec req2");
    apb(1'b0, 8'h04, 32'h0);
    wt(2);
    rchk(8'h00, 32'h0C, "flag2 clr");
  endtask

  task automatic t_bad();
    apb(1'b0, 8'h48, 32'h0);
    chk(er, 1'b1, "unmapped read err");
    chk(rd, 32'h0, "unmapped read data");
    apb(1'b1, 8'h4C, 32'hFF);
    chk(er, 1'b1, "unmapped write");
    apb(1'b0, 8'h01, 32'h0);
    chk(er, 1'b1, "misaligned");
    apb(1'b0, 8'h3C, 32'h0);
    chk(er, 1'b0, "last port");
  endtask

  // Reset in mid-run after the ports were configured
  task automatic t_rst_mid();
    presetn <= 1'b0;
    wt(2);
    chk(pd_oe[31:0] | pd_oe[63:32], 32'h0, "mid reset dir");
    presetn <= 1'b1;
    t_reset();
  endtask

  ////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    drv_data = 64'h3C96_3C96_3C96_3C96;
    drv_hs1 = 8'h00;
    drv_hs2 = 8'hFF;
    err_total = 0;
    checks = 0;
    cyc = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_dir();
    t_hs1();
    t_hs2();
    t_rst_mid();
    t_bad();
    stop_test();
  end
endmodule // pph_top_tb
